// *** rtl/cibl_pkg.sv ***
package cibl_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [11:0] ADDR_SWITCH_BANK = 12'h000;
    localparam logic [11:0] ADDR_LINK_CFG    = 12'h004;
    localparam logic [11:0] ADDR_STATUS      = 12'h008;
    localparam logic [11:0] ADDR_STAGE_IN    = 12'h00c;

    localparam logic [7:0]  SWITCH_BANK_RST  = 8'h00;
    localparam logic        LINK_CFG_RST     = 1'b0;

    // ********************************************************************
    // Switch bank bit positions
    // ********************************************************************
    localparam int SW_BLK_OVERLOAD  = 0;
    localparam int SW_BLK_UNBAL     = 1;
    localparam int SW_BLK_UNDERCUR  = 2;
    localparam int SW_EXT_INHIBIT   = 3;
    localparam int SW_EXT_TRIP      = 4;
    localparam int SW_LATCH_OVL_HI  = 5;
    localparam int SW_LATCH_UNBAL2  = 6;
    localparam int SW_EXT_RESET     = 7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************************
    // Carrier types
    // ********************************************************************
    typedef struct packed {
        logic ovl_a;
        logic ovl_b;
        logic unbal_1;
        logic unbal_2;
        logic undercur;
    } cibl_stage_t;

    typedef struct packed {
        logic reset_btn;
        logic program_btn;
        logic display_blank;
    } cibl_panel_t;

endpackage : cibl_pkg

// *** rtl/cibl_control_input.sv ***
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module cibl_control_input (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 ext_control_input_one,
    input  wire cibl_pkg::cibl_stage_t stage_trip,
    input  wire cibl_pkg::cibl_panel_t panel,
    output cibl_pkg::cibl_stage_t     trip_out_ff,
    output logic                      trip_output_two_ff,
    output logic                      reconnect_inhibit_ext_ff,
    output logic                      relay_a_trip_ff,
    output logic                      module_reset_ff
);

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    logic [2:0] ext_sync_ff;
    logic       ext_in_ff;
    logic [2:0] rst_btn_sync_ff;
    logic [2:0] prg_btn_sync_ff;
    logic [2:0] blank_sync_ff;
    logic       rst_btn_ff;
    logic       prg_btn_ff;
    logic       blank_ff;

    // Change counts only when stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic prev);
        return (s[1] == s[2]) ? s[2] : prev;
    endfunction : filt

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync_ff <= 3'h0;
            ext_in_ff   <= 1'b0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[1:0], ext_control_input_one};
            ext_in_ff   <= filt(ext_sync_ff, ext_in_ff);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_btn_sync_ff <= 3'h0;
            rst_btn_ff      <= 1'b0;
        end else begin
            rst_btn_sync_ff <= {rst_btn_sync_ff[1:0], panel.reset_btn};
            rst_btn_ff      <= filt(rst_btn_sync_ff, rst_btn_ff);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prg_btn_sync_ff <= 3'h0;
            prg_btn_ff      <= 1'b0;
        end else begin
            prg_btn_sync_ff <= {prg_btn_sync_ff[1:0], panel.program_btn};
            prg_btn_ff      <= filt(prg_btn_sync_ff, prg_btn_ff);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blank_sync_ff <= 3'h0;
            blank_ff      <= 1'b0;
        end else begin
            blank_sync_ff <= {blank_sync_ff[1:0], panel.display_blank};
            blank_ff      <= filt(blank_sync_ff, blank_ff);
        end
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    logic [7:0] first_input_switch_bank_ff;
    logic       link_ovl_a_ff;
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;

    logic do_write;
    logic wr_bank;
    logic wr_link;

    assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;

    // Every mapped word, read-only ones included, answers OKAY
    function automatic logic addr_known(input logic [11:0] a);
        return (a == cibl_pkg::ADDR_SWITCH_BANK) ||
               (a == cibl_pkg::ADDR_LINK_CFG) ||
               (a == cibl_pkg::ADDR_STATUS) ||
               (a == cibl_pkg::ADDR_STAGE_IN);
    endfunction : addr_known

    // Only the low byte lane carries settings
    assign wr_bank = do_write && wstrb_ff[0] && (awaddr_ff == cibl_pkg::ADDR_SWITCH_BANK);
    assign wr_link = do_write && wstrb_ff[0] && (awaddr_ff == cibl_pkg::ADDR_LINK_CFG);

    // ********************************************************************
    // Write channel
    // ********************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff     <= 1'b0;
            awaddr_ff     <= 12'h000;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            if (s_axi_awvalid && !aw_got_ff && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_got_ff     <= 1'b1;
                awaddr_ff     <= s_axi_awaddr;
            end
            if (do_write) begin
                aw_got_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff     <= 1'b0;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= 1'b0;
            if (s_axi_wvalid && !w_got_ff && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_got_ff     <= 1'b1;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
            end
            if (do_write) begin
                w_got_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cibl_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(awaddr_ff) ? cibl_pkg::RESP_OKAY
                                                  : cibl_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Switch settings survive the module reset from input one; only aresetn
    // returns them to factory state, otherwise the reset could disable itself.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_input_switch_bank_ff <= cibl_pkg::SWITCH_BANK_RST;
        end else if (wr_bank) begin
            first_input_switch_bank_ff <= wdata_ff[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_ovl_a_ff <= cibl_pkg::LINK_CFG_RST;
        end else if (wr_link) begin
            link_ovl_a_ff <= wdata_ff[0];
        end
    end

    // ********************************************************************
    // Control logic
    // ********************************************************************
    logic [7:0] sw;
    logic       blk_ovl;
    logic       blk_unb;
    logic       blk_und;
    logic       ext_rst;
    logic       btn_clear;
    logic       ovl_b_latch_ff;
    logic       unbal_2_latch_ff;
    logic       ovl_b_gated;
    logic       unbal_2_gated;

    assign sw      = first_input_switch_bank_ff;
    assign blk_ovl = ext_in_ff && sw[cibl_pkg::SW_BLK_OVERLOAD];
    assign blk_unb = ext_in_ff && sw[cibl_pkg::SW_BLK_UNBAL];
    assign blk_und = ext_in_ff && sw[cibl_pkg::SW_BLK_UNDERCUR];
    assign ext_rst = ext_in_ff && sw[cibl_pkg::SW_EXT_RESET];
    // Both buttons, or program alone with the display dark
    assign btn_clear = (rst_btn_ff && prg_btn_ff) || (prg_btn_ff && blank_ff);

    assign ovl_b_gated   = stage_trip.ovl_b && !blk_ovl;
    assign unbal_2_gated = stage_trip.unbal_2 && !blk_unb;

    // ********************************************************************
    // Trip latches
    // ********************************************************************
    // A live trip wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovl_b_latch_ff <= 1'b0;
        end else if (ovl_b_gated && sw[cibl_pkg::SW_LATCH_OVL_HI]) begin
            ovl_b_latch_ff <= 1'b1;
        end else if (btn_clear || ext_rst || !sw[cibl_pkg::SW_LATCH_OVL_HI]) begin
            ovl_b_latch_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unbal_2_latch_ff <= 1'b0;
        end else if (unbal_2_gated && sw[cibl_pkg::SW_LATCH_UNBAL2]) begin
            unbal_2_latch_ff <= 1'b1;
        end else if (btn_clear || ext_rst || !sw[cibl_pkg::SW_LATCH_UNBAL2]) begin
            unbal_2_latch_ff <= 1'b0;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_out_ff <= '0;
        end else begin
            trip_out_ff.ovl_a    <= stage_trip.ovl_a && !blk_ovl;
            trip_out_ff.ovl_b    <= (ovl_b_gated || ovl_b_latch_ff) && !ext_rst;
            trip_out_ff.unbal_1  <= stage_trip.unbal_1 && !blk_unb;
            trip_out_ff.unbal_2  <= (unbal_2_gated || unbal_2_latch_ff) && !ext_rst;
            trip_out_ff.undercur <= stage_trip.undercur && !blk_und;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_output_two_ff <= 1'b0;
        end else begin
            trip_output_two_ff <= link_ovl_a_ff && stage_trip.ovl_a && !blk_ovl;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reconnect_inhibit_ext_ff <= 1'b0;
        end else begin
            reconnect_inhibit_ext_ff <= ext_in_ff && sw[cibl_pkg::SW_EXT_INHIBIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relay_a_trip_ff <= 1'b0;
        end else begin
            // Trip indication for this path belongs to the external relay
            relay_a_trip_ff <= ext_in_ff && sw[cibl_pkg::SW_EXT_TRIP];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_reset_ff <= 1'b0;
        end else begin
            module_reset_ff <= ext_rst;
        end
    end

    // ********************************************************************
    // Read channel
    // ********************************************************************
    logic [31:0] status_word;
    logic [31:0] stage_word;

    // Live flags, so software sees what the output pins are doing
    assign status_word = {26'h000_0000, module_reset_ff, relay_a_trip_ff,
                          reconnect_inhibit_ext_ff, unbal_2_latch_ff,
                          ovl_b_latch_ff, ext_in_ff};
    assign stage_word  = {26'h000_0000, trip_output_two_ff, trip_out_ff};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= cibl_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= cibl_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    cibl_pkg::ADDR_SWITCH_BANK: s_axi_rdata <= {24'h0, sw};
                    cibl_pkg::ADDR_LINK_CFG:    s_axi_rdata <= {31'h0, link_ovl_a_ff};
                    cibl_pkg::ADDR_STATUS:      s_axi_rdata <= status_word;
                    cibl_pkg::ADDR_STAGE_IN:    s_axi_rdata <= stage_word;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= cibl_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule : cibl_control_input

// *** tb/cibl_control_input_props.sv ***
`timescale 1ns/10ps
module cibl_control_input_props (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  ext_control_input_one,
    input wire cibl_pkg::cibl_stage_t stage_trip,
    input wire cibl_pkg::cibl_stage_t trip_out_ff,
    input wire logic                  trip_output_two_ff,
    input wire logic                  reconnect_inhibit_ext_ff,
    input wire logic                  relay_a_trip_ff,
    input wire logic                  module_reset_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst_quiet;
        $rose(aresetn) |-> trip_out_ff == 5'h00 && !relay_a_trip_ff && !module_reset_ff;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_relay_a_cause;
        $rose(relay_a_trip_ff) |-> $past(ext_control_input_one, 2);
    endproperty
    a_relay_a_cause: assert property (p_relay_a_cause) else $error("relay A without input");
    property p_inhibit_cause;
        $rose(reconnect_inhibit_ext_ff) |-> $past(ext_control_input_one, 2);
    endproperty
    a_inhibit_cause: assert property (p_inhibit_cause) else $error("inhibit without input");
    property p_mod_rst_cause;
        $rose(module_reset_ff) |-> $past(ext_control_input_one, 2);
    endproperty
    a_mod_rst_cause: assert property (p_mod_rst_cause) else $error("reset without input");
    property p_ovl_a_src;
        trip_out_ff.ovl_a |-> $past(stage_trip.ovl_a);
    endproperty
    a_ovl_a_src: assert property (p_ovl_a_src) else $error("overload a trip unsourced");
    property p_unbal1_src;
        trip_out_ff.unbal_1 |-> $past(stage_trip.unbal_1);
    endproperty
    a_unbal1_src: assert property (p_unbal1_src) else $error("unbalance 1 trip unsourced");
    property p_undercur_src;
        trip_out_ff.undercur |-> $past(stage_trip.undercur);
    endproperty
    a_undercur_src: assert property (p_undercur_src) else $error("undercurrent unsourced");
    property p_ovl_b_set;
        $rose(trip_out_ff.ovl_b) |-> $past(stage_trip.ovl_b);
    endproperty
    a_ovl_b_set: assert property (p_ovl_b_set) else $error("overload high set unsourced");
    property p_unbal2_set;
        $rose(trip_out_ff.unbal_2) |-> $past(stage_trip.unbal_2);
    endproperty
    a_unbal2_set: assert property (p_unbal2_set) else $error("unbalance 2 set unsourced");
    property p_link_src;
        trip_output_two_ff |-> $past(stage_trip.ovl_a);
    endproperty
    a_link_src: assert property (p_link_src) else $error("trip output two unsourced");
endmodule : cibl_control_input_props

// *** tb/cibl_ext_relay.sv ***
`timescale 1ns/10ps
// ********************************************************************
// External protective relay and its contact
// ********************************************************************
module cibl_ext_relay (
    input  wire logic aclk,
    input  wire logic trip_cmd,
    output logic      contact,
    output logic      signal_contact
);
    initial begin
        contact = 1'b0;
        signal_contact = 1'b0;
    end
    // The block never signals a routed trip, so the relay keeps its own flag
    always @(posedge aclk) begin
        contact <= trip_cmd;
        signal_contact <= trip_cmd;
    end
endmodule : cibl_ext_relay

// *** tb/cibl_control_input_tb.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD %0t mismatch", $time); end end
module cibl_control_input_tb;
    logic                  aclk = 1'b0, aresetn = 1'b0, trip_cmd = 1'b0;
    logic [11:0]           awaddr = 12'h000, araddr = 12'h000;
    logic [31:0]           wdata = 32'h0, rdata;
    logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                  arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic                  arready, rvalid, ext_in, sig_contact, two, inhibit, relay_a, mod_rst;
    logic [1:0]            bresp, rresp;
    cibl_pkg::cibl_stage_t stage = 5'h00, trip_out;
    cibl_pkg::cibl_panel_t panel = 3'h0;
    int                    bad_count = 0, n_compared = 0, cycles = 0;

    always #2 aclk = ~aclk;

    cibl_ext_relay u_relay (.aclk(aclk), .trip_cmd(trip_cmd), .contact(ext_in),
        .signal_contact(sig_contact));
    cibl_control_input u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_control_input_one(ext_in), .stage_trip(stage),
        .panel(panel), .trip_out_ff(trip_out), .trip_output_two_ff(two),
        .reconnect_inhibit_ext_ff(inhibit), .relay_a_trip_ff(relay_a),
        .module_reset_ff(mod_rst));

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        tick(1);
    endtask : rd

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rd(cibl_pkg::ADDR_SWITCH_BANK, d, r);
        `CHK(d, 32'h0)
        rd(cibl_pkg::ADDR_LINK_CFG, d, r);
        `CHK(d, 32'h0)
        wr(cibl_pkg::ADDR_SWITCH_BANK, 32'h5a);
        `CHK(bresp, cibl_pkg::RESP_OKAY)
        wr(12'h010, 32'h0);
        `CHK(bresp, cibl_pkg::RESP_SLVERR)
        rd(cibl_pkg::ADDR_SWITCH_BANK, d, r);
        `CHK(d, 32'h5a)
        rd(cibl_pkg::ADDR_STATUS, d, r);
        `CHK(d, 32'h0)
        rd(12'h010, d, r);
        `CHK(r, cibl_pkg::RESP_SLVERR)
    endtask : t_regs

    task automatic t_block;
        logic [7:0] bank [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
        logic [4:0] mask [4] = '{5'h00, 5'h18, 5'h06, 5'h01};
        for (int i = 0; i < 4; i++) begin
            wr(cibl_pkg::ADDR_SWITCH_BANK, {24'h0, bank[i]});
            trip_cmd <= 1'b1;
            tick(12);
            stage <= 5'h1f;
            tick(4);
            `CHK(trip_out, ~mask[i])
            stage <= 5'h00;
            trip_cmd <= 1'b0;
            tick(12);
        end
    endtask : t_block

    task automatic t_ext;
        logic [7:0] bank [3] = '{8'h08, 8'h10, 8'h00};
        for (int i = 0; i < 3; i++) begin
            wr(cibl_pkg::ADDR_SWITCH_BANK, {24'h0, bank[i]});
            trip_cmd <= 1'b1;
            tick(12);
            `CHK(inhibit, bank[i][3])
            `CHK(relay_a, bank[i][4])
            `CHK(sig_contact, 1'b1)
            trip_cmd <= 1'b0;
            tick(12);
            `CHK({inhibit, relay_a}, 2'b00)
        end
    endtask : t_ext

    // Pulse both latchable stages, then try one way of clearing them
    task automatic t_latch(input logic [7:0] bank, input cibl_pkg::cibl_panel_t clr,
                           input logic ext, input logic [4:0] hold, input logic [4:0] left);
        wr(cibl_pkg::ADDR_SWITCH_BANK, {24'h0, bank});
        stage <= 5'h0a;
        tick(4);
        stage <= 5'h00;
        tick(4);
        `CHK(trip_out, hold)
        panel <= clr;
        trip_cmd <= ext;
        tick(12);
        `CHK(trip_out, left)
        `CHK(mod_rst, ext)
        panel <= 3'h0;
        trip_cmd <= 1'b0;
        tick(12);
    endtask : t_latch

    task automatic t_link;
        wr(cibl_pkg::ADDR_SWITCH_BANK, 32'h0);
        wr(cibl_pkg::ADDR_LINK_CFG, 32'h1);
        stage <= 5'h10;
        tick(4);
        `CHK(two, 1'b1)
        wr(cibl_pkg::ADDR_LINK_CFG, 32'h0);
        tick(2);
        `CHK(two, 1'b0)
        stage <= 5'h00;
    endtask : t_link

    task automatic tally_and_finish;
        $display("TB: compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Ceiling is some forty-five times the expected run so a hung handshake ends cleanly
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        tick(4);
        aresetn <= 1'b1;
        tick(1);
        t_regs();
        t_block();
        t_ext();
        t_latch(8'h00, 3'h0, 1'b0, 5'h00, 5'h00);
        t_latch(8'h60, 3'h6, 1'b0, 5'h0a, 5'h00);
        t_latch(8'h60, 3'h3, 1'b0, 5'h0a, 5'h00);
        t_latch(8'h60, 3'h2, 1'b0, 5'h0a, 5'h0a);
        t_latch(8'he0, 3'h0, 1'b1, 5'h0a, 5'h00);
        t_link();
        tally_and_finish();
    end
endmodule : cibl_control_input_tb

bind cibl_control_input cibl_control_input_props u_props (.aclk, .aresetn,
    .ext_control_input_one, .stage_trip, .trip_out_ff, .trip_output_two_ff,
    .reconnect_inhibit_ext_ff, .relay_a_trip_ff, .module_reset_ff);
